// *** dmem_params.svh ***
// Constants for the core memory organization block.
`ifndef DMEM_PARAMS_SVH
`define DMEM_PARAMS_SVH
`define DMEM_PC_W 24
`define DMEM_PC_RESET 24'h000000
`define DMEM_PC_STEP 24'h000002
`define DMEM_VEC_END 24'h000200
`define DMEM_IVT1_LO 24'h000004
`define DMEM_IVT1_HI 24'h0000ff
`define DMEM_IVT2_LO 24'h000100
`define DMEM_IVT2_HI 24'h0001ff
`define DMEM_PW_W 24
`define DMEM_DW 16
`define DMEM_AW 16
`define DMEM_WORDS 32768
`define DMEM_WA_W 15
`define DMEM_Y_BASE 16'h8000
`define DMEM_DPR_BASE 16'hf800
`define DMEM_DPR_WORDS 1024
`define DMEM_DPR_AW 10
`define DMEM_RAM_WORDS 2048
`define DMEM_RAM_AW 11
`define DMEM_PM_WORDS 1024
`define DMEM_PM_AW 10
`define DMEM_WORD_STEP 16'h0002
`define DMEM_RAM_LIMIT 16'h1000
`endif

// *** dmem_pkg.sv ***
// Types shared by the core memory organization block.
package dmem_pkg;
  // Program fetch request.
  typedef struct packed {
    logic step;
    logic down;
    logic load;
    logic [23:0] target;
  } dmem_pc_cmd_t;
  // One data port access.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmem_acc_t;
  // Address generation mode.
  typedef enum logic [1:0] {
    DMEM_AM_LIN = 2'b00,
    DMEM_AM_MOD = 2'b01,
    DMEM_AM_REV = 2'b11
  } dmem_am_t;
endpackage

// *** dmem_core.sv ***
// Program counter, address generators, unified X/Y data RAM and dual-ported DMA RAM.
`timescale 1ns/1ps
`default_nettype none
`include "dmem_params.svh"

//------------------------------------------------------------
// Core memory organization top
//------------------------------------------------------------
// Behaviour
// RQ1 - Program memory holds 24-bit words read as a lower even half and a masked upper odd half.
// RQ2 - The program counter stays even and moves up or down by two per instruction word.
// RQ3 - Program addresses below 0x000200 are flagged as the fixed vector area.
// RQ4 - Execution starts at address zero after reset, where user code keeps its jump.
// RQ5 - Accesses inside the two interrupt vector tables are flagged per table.
// RQ6 - X and Y data use two separate address generators and data paths.
// RQ7 - X space takes every access, owns the write bus and the unified read bus.
// RQ8 - Y space is read on its own path only for multiply-accumulate class operations.
// RQ9 - Modulo addressing works in X and Y, bit reversal only for X writes.
// RQ10 - Every data write decodes against the one unified range with a fixed X/Y boundary.
// RQ11 - Data addresses are 16-bit byte addresses over a 32K-word space, partly populated.
// RQ12 - A 2 Kbyte dual-ported RAM sits at the top of Y space.
// RQ13 - Core and DMA reach the dual-ported RAM in the same cycle with no stall.
// RQ14 - On a same-location double write the core write wins and the core never stalls.
// RQ15 - Software may use the dual-ported RAM as plain Y RAM when DMA is unused.
// RQ16 - Same-location double reads return the stored word and a losing DMA write is dropped silently.
module dmem_core
  import dmem_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Program counter control and program memory write.
  input wire dmem_pc_cmd_t pc_cmd,
  input wire logic pm_we,
  input wire logic [23:0] pm_waddr,
  input wire logic [23:0] pm_wdata,
  // Program fetch results.
  output logic [23:0] pc_r,
  output logic [15:0] prog_lo_r,
  output logic [15:0] prog_hi_r,
  output logic vec_area_r,
  output logic ivt1_hit_r,
  output logic ivt2_hit_r,
  // X port: unified reads and all writes.
  input wire dmem_acc_t x_acc,
  input wire dmem_am_t x_mode,
  input wire logic [15:0] x_mod_lo,
  input wire logic [15:0] x_mod_hi,
  output logic [15:0] x_rdata_r,
  output logic [15:0] x_ea_r,
  // Y port: multiply-accumulate operand reads.
  input wire logic mac_op,
  input wire logic y_rd,
  input wire logic [15:0] y_addr,
  input wire logic y_mod_en,
  input wire logic [15:0] y_mod_lo,
  input wire logic [15:0] y_mod_hi,
  output logic [15:0] y_rdata_r,
  // DMA port to the dual-ported RAM.
  input wire logic dma_rd,
  input wire logic dma_wr,
  input wire logic [9:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  output logic [15:0] dma_rdata_r
);

  //------------------------------------------------------------
  // Storage
  //------------------------------------------------------------
  logic [23:0] pmem [0:`DMEM_PM_WORDS-1];
  logic [15:0] ram [0:`DMEM_RAM_WORDS-1];
  logic [15:0] dpr [0:`DMEM_DPR_WORDS-1];

  //------------------------------------------------------------
  // Program counter
  //------------------------------------------------------------
  logic [23:0] pc_nxt;
  logic [23:0] pw;
  // Steps by two and forces bit 0 low on a jump load.
  always_comb
  begin
    pc_nxt = pc_r;
    if (pc_cmd.load)
    begin
      pc_nxt = {pc_cmd.target[23:1], 1'b0}; // [RQ2]
    end
    else if (pc_cmd.step)
    begin
      pc_nxt = pc_cmd.down ? pc_r - `DMEM_PC_STEP : pc_r + `DMEM_PC_STEP; // [RQ2]
    end
  end

  // Reset puts execution at the reset location.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_r <= `DMEM_PC_RESET; // [RQ4]
    end
    else
    begin
      pc_r <= pc_nxt;
    end
  end

  // Fetch word at the current even address; upper byte reads as zero.
  assign pw = pmem[pc_r[`DMEM_PM_AW:1]];
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_lo_r <= 16'h0000;
      prog_hi_r <= 16'h0000;
      vec_area_r <= 1'b0;
      ivt1_hit_r <= 1'b0;
      ivt2_hit_r <= 1'b0;
    end
    else
    begin
      prog_lo_r <= pw[15:0]; // [RQ1]
      prog_hi_r <= {8'h00, pw[23:16]}; // [RQ1]
      vec_area_r <= (pc_r < `DMEM_VEC_END); // [RQ3]
      ivt1_hit_r <= (pc_r >= `DMEM_IVT1_LO) && (pc_r <= `DMEM_IVT1_HI); // [RQ5]
      ivt2_hit_r <= (pc_r >= `DMEM_IVT2_LO) && (pc_r <= `DMEM_IVT2_HI); // [RQ5]
    end
  end

  // Program memory load port.
  always_ff @(posedge ref_clk)
  begin
    if (pm_we)
    begin
      pmem[pm_waddr[`DMEM_PM_AW:1]] <= pm_wdata;
    end
  end

  //------------------------------------------------------------
  // Address generators
  //------------------------------------------------------------
  logic [15:0] x_ea;
  logic [15:0] y_ea;
  logic x_rev;
  // X generator: modulo wrap, bit reversal only for writes.
  always_comb
  begin
    x_rev = (x_mode == DMEM_AM_REV) && x_acc.wr; // [RQ9]
    x_ea = x_acc.addr;
    if (x_rev)
    begin
      for (int i = 1; i < 16; i++)
      begin
        x_ea[i] = x_acc.addr[16-i];
      end
      x_ea[0] = 1'b0;
    end
    else if (x_mode != DMEM_AM_LIN && x_acc.addr > x_mod_hi)
    begin
      x_ea = x_mod_lo + (x_acc.addr - x_mod_hi) - `DMEM_WORD_STEP; // [RQ9]
    end
  end

  // Y generator: modulo wrap only.
  always_comb
  begin
    y_ea = y_addr;
    if (y_mod_en && y_addr > y_mod_hi)
    begin
      y_ea = y_mod_lo + (y_addr - y_mod_hi) - `DMEM_WORD_STEP; // [RQ9]
    end
  end

  //------------------------------------------------------------
  // Unified decode and data paths
  //------------------------------------------------------------
  logic x_in_dpr;
  logic y_in_dpr;
  logic [`DMEM_DPR_AW-1:0] x_dpa;
  logic [`DMEM_DPR_AW-1:0] y_dpa;
  logic y_go;
  logic dma_we;
  // Byte addresses map to word slots; top 2 Kbytes go to the shared RAM.
  always_comb
  begin
    x_in_dpr = (x_ea >= `DMEM_DPR_BASE); // [RQ10] [RQ12]
    y_in_dpr = (y_ea >= `DMEM_DPR_BASE); // [RQ12]
    x_dpa = x_ea[`DMEM_DPR_AW:1]; // [RQ11]
    y_dpa = y_ea[`DMEM_DPR_AW:1];
    y_go = y_rd && mac_op; // [RQ8]
    dma_we = dma_wr && !(x_acc.wr && x_in_dpr && x_dpa == dma_addr); // [RQ14] [RQ16]
  end

  // Core writes to plain RAM; unpopulated addresses are ignored.
  always_ff @(posedge ref_clk)
  begin
    if (x_acc.wr && !x_in_dpr && x_ea < `DMEM_RAM_LIMIT)
    begin
      ram[x_ea[`DMEM_RAM_AW:1]] <= x_acc.wdata; // [RQ7] [RQ11]
    end
  end

  // Shared RAM: both writers in one cycle, core first.
  always_ff @(posedge ref_clk)
  begin
    if (x_acc.wr && x_in_dpr)
    begin
      dpr[x_dpa] <= x_acc.wdata; // [RQ13] [RQ15]
    end
    if (dma_we)
    begin
      dpr[dma_addr] <= dma_wdata; // [RQ13]
    end
  end

  // Read ports; each returns the stored word regardless of the other.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      x_rdata_r <= 16'h0000;
      y_rdata_r <= 16'h0000;
      dma_rdata_r <= 16'h0000;
      x_ea_r <= 16'h0000;
    end
    else
    begin
      x_ea_r <= x_ea; // [RQ6]
      if (x_acc.rd)
      begin
        x_rdata_r <= x_in_dpr ? dpr[x_dpa] :
          (x_ea < `DMEM_RAM_LIMIT ? ram[x_ea[`DMEM_RAM_AW:1]] : 16'h0000); // [RQ7]
      end
      if (y_go)
      begin
        y_rdata_r <= y_in_dpr ? dpr[y_dpa] :
          (y_ea < `DMEM_RAM_LIMIT ? ram[y_ea[`DMEM_RAM_AW:1]] : 16'h0000); // [RQ6] [RQ8]
      end
      if (dma_rd)
      begin
        dma_rdata_r <= dpr[dma_addr]; // [RQ16]
      end
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  property p_pc_even;
    @(posedge ref_clk) disable iff (!rstn) pc_r[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc odd"); // [RQ2]

  property p_pc_step;
    @(posedge ref_clk) disable iff (!rstn)
      (pc_cmd.step && !pc_cmd.load && !pc_cmd.down) |=> pc_r == $past(pc_r) + `DMEM_PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc step wrong"); // [RQ2]

  property p_hi_byte;
    @(posedge ref_clk) disable iff (!rstn) prog_hi_r[15:8] == 8'h00;
  endproperty
  a_hi_byte: assert property (p_hi_byte) else $error("upper byte set"); // [RQ1]

  property p_vec;
    @(posedge ref_clk) disable iff (!rstn) (pc_r < `DMEM_VEC_END) |=> vec_area_r;
  endproperty
  a_vec: assert property (p_vec) else $error("vector flag missing"); // [RQ3]

  property p_ivt2;
    @(posedge ref_clk) disable iff (!rstn)
      (pc_r >= `DMEM_IVT2_LO && pc_r <= `DMEM_IVT2_HI) |=> ivt2_hit_r && !ivt1_hit_r;
  endproperty
  a_ivt2: assert property (p_ivt2) else $error("ivt flag wrong"); // [RQ5]

  property p_y_hold;
    @(posedge ref_clk) disable iff (!rstn) !mac_op |=> $stable(y_rdata_r);
  endproperty
  a_y_hold: assert property (p_y_hold) else $error("y read without mac"); // [RQ8]

  property p_cpu_wins;
    @(posedge ref_clk) disable iff (!rstn)
      (dma_wr && x_acc.wr && x_in_dpr && x_dpa == dma_addr) |-> !dma_we;
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("dma beat core"); // [RQ14]

  sequence s_dual_read;
    dma_rd && x_acc.rd && x_in_dpr && x_dpa == dma_addr && !x_acc.wr && !dma_wr;
  endsequence
  property p_same_read;
    @(posedge ref_clk) disable iff (!rstn) s_dual_read |=> x_rdata_r == dma_rdata_r;
  endproperty
  a_same_read: assert property (p_same_read) else $error("dual read mismatch"); // [RQ16]

  property p_rev_x;
    @(posedge ref_clk) disable iff (!rstn)
      (x_mode == DMEM_AM_REV && !x_acc.wr) |-> x_ea == x_acc.addr || x_acc.addr > x_mod_hi;
  endproperty
  a_rev_x: assert property (p_rev_x) else $error("reversal on read"); // [RQ9]

endmodule // dmem_core
`default_nettype wire

// *** dcmo_dma_model.sv ***
// DMA controller model on the far port of the dual-ported RAM.
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------
// DMA side model
//----------------------------------------
module dcmo_dma_model (
  // DMA port of the shared RAM.
  output var logic dma_rd,
  output var logic dma_wr,
  output var logic [9:0] dma_addr,
  output var logic [15:0] dma_wdata
);
  // Idle port at time zero.
  initial
  begin
    dma_rd = 1'b0;
    dma_wr = 1'b0;
    dma_addr = 10'h000;
    dma_wdata = 16'h0000;
  end
  // Posts one access without waiting on the core side.
  task automatic put(input logic w, input logic [9:0] a, input logic [15:0] d);
    dma_rd = ~w;
    dma_wr = w;
    dma_addr = a;
    dma_wdata = d;
  endtask
  // Releases the port; stale lines are inverted so old values cannot pass.
  task automatic idle();
    dma_rd = 1'b0;
    dma_wr = 1'b0;
    dma_addr = ~dma_addr;
    dma_wdata = ~dma_wdata;
  endtask
endmodule // dcmo_dma_model
`default_nettype wire

// *** dsp_core_memory_organization_test.sv ***
// Self-checking testbench of the core memory organization block.
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------
// Testbench top
//----------------------------------------
module dsp_core_memory_organization_test
  import dmem_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  dmem_pc_cmd_t pc_cmd = '0;
  logic pm_we = 1'b0;
  logic [23:0] pm_waddr = 24'h0;
  logic [23:0] pm_wdata = 24'h0;
  logic [23:0] pc_r;
  logic [15:0] prog_lo_r, prog_hi_r, x_rdata_r, y_rdata_r, dma_rdata_r;
  logic vec_area_r, ivt1_hit_r, ivt2_hit_r;
  dmem_acc_t x_acc = '0;
  logic mac_op = 1'b0;
  logic y_rd = 1'b0;
  logic [15:0] y_addr = 16'h0;
  dmem_am_t x_mode = DMEM_AM_LIN;
  logic [15:0] x_mod_lo = 16'h0, x_mod_hi = 16'h0, y_mod_lo = 16'h0, y_mod_hi = 16'h0;
  logic y_mod_en = 1'b0;
  logic [15:0] x_ea_r;
  logic dma_rd, dma_wr;
  logic [9:0] dma_addr, k;
  logic [15:0] dma_wdata;
  logic [31:0] a, b;
  logic [23:0] w [8];
  logic [23:0] tv [8] = '{24'h0, 24'h2, 24'h4, 24'hfe, 24'h100, 24'h1fe, 24'h200, 24'h3fe};
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h428445f7;
  int i;

  dmem_core i_dut (.ref_clk(ref_clk), .rstn(rstn), .pc_cmd(pc_cmd), .pm_we(pm_we),
    .pm_waddr(pm_waddr), .pm_wdata(pm_wdata), .pc_r(pc_r), .prog_lo_r(prog_lo_r),
    .prog_hi_r(prog_hi_r), .vec_area_r(vec_area_r), .ivt1_hit_r(ivt1_hit_r),
    .ivt2_hit_r(ivt2_hit_r), .x_acc(x_acc), .x_mode(x_mode), .x_mod_lo(x_mod_lo),
    .x_mod_hi(x_mod_hi), .x_rdata_r(x_rdata_r), .x_ea_r(x_ea_r), .mac_op(mac_op),
    .y_rd(y_rd), .y_addr(y_addr), .y_mod_en(y_mod_en), .y_mod_lo(y_mod_lo),
    .y_mod_hi(y_mod_hi),
    .y_rdata_r(y_rdata_r), .dma_rd(dma_rd), .dma_wr(dma_wr), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_rdata_r(dma_rdata_r));
  dcmo_dma_model i_dma (.dma_rd(dma_rd), .dma_wr(dma_wr), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata));

  // Clock and hang guard.
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // Loads an odd target; bit 0 must drop and flags follow a cycle later.
  task automatic fetch(input logic [23:0] t, input logic [23:0] d);
    pc_cmd = '{step: 1'b0, down: 1'b0, load: 1'b1, target: t | 24'h1};
    tick();
    pc_cmd.load = 1'b0;
    chk(pc_r, t, "pc load");
    tick();
    chk(prog_lo_r, d[15:0], "low word");
    chk(prog_hi_r, {16'h0, d[23:16]}, "high word");
    chk(vec_area_r, t < 24'h200, "vector area");
    chk(ivt1_hit_r, t >= 24'h4 && t <= 24'hff, "table one");
    chk(ivt2_hit_r, t >= 24'h100 && t <= 24'h1ff, "table two");
  endtask
  // One cycle on the core X port and the DMA port together; the lines stand until the caller moves on.
  task automatic both(input logic xw, input logic [9:0] xk, input logic [15:0] xd,
    input logic dw, input logic [9:0] dk, input logic [15:0] dd);
    x_acc = '{rd: ~xw, wr: xw, addr: 16'hf800 + {5'h0, xk, 1'b0}, wdata: xd};
    i_dma.put(dw, dk, dd);
    tick();
  endtask
  // Expected modulo wrap: past the top the address restarts near the bottom.
  function automatic logic [15:0] mod_ea(input logic [15:0] ad, input logic [15:0] lo,
    input logic [15:0] hi);
    return (ad > hi) ? lo + (ad - hi) - 16'h0002 : ad;
  endfunction
  // Expected bit-reversed address: bits 15..1 mirrored, bit 0 cleared.
  function automatic logic [15:0] rev_ea(input logic [15:0] ad);
    logic [15:0] r;
    r = 16'h0;
    for (int j = 1; j < 16; j++)
      r[j] = ad[16 - j];
    return r;
  endfunction

  // Main sequence.
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    chk(pc_r, 24'h0, "reset pc");
    for (i = 0; i < 8; i++)
    begin
      a = $random(seed);
      w[i] = a[23:0];
      pm_we = 1'b1;
      pm_waddr = tv[i];
      pm_wdata = w[i];
      tick();
    end
    pm_we = 1'b0;
    for (i = 0; i < 8; i++)
      fetch(tv[i], w[i]);
    pc_cmd.step = 1'b1;
    for (i = 1; i <= 3; i++)
    begin
      tick();
      chk(pc_r, 24'h3fe + 24'(2 * i), "step up");
    end
    pc_cmd.down = 1'b1;
    tick();
    chk(pc_r, 24'h402, "step down");
    pc_cmd = '0;
    rstn = 1'b0;
    tick();
    chk(pc_r, 24'h0, "pc in reset");
    chk(vec_area_r, 24'h0, "flag in reset");
    rstn = 1'b1;
    tick();
    chk(vec_area_r, 24'h1, "restart in vector area");
    chk(prog_lo_r, w[0][15:0], "jump word at zero");
    for (i = 0; i < 7; i++)
    begin
      a = $random(seed);
      b[15:0] = (i == 0) ? 16'h0ffe : (i == 6) ? 16'h4000 : {4'h0, a[11:1], 1'b0};
      x_acc = '{rd: 1'b0, wr: 1'b1, addr: b[15:0], wdata: a[31:16]};
      tick();
      x_acc = '{rd: 1'b1, wr: 1'b0, addr: b[15:0] | 16'h0001, wdata: 16'h0};
      tick();
      chk(x_rdata_r, (i == 6) ? 24'h0 : {8'h0, a[31:16]}, "x ram");
      chk(x_ea_r, {8'h0, b[15:0] | 16'h0001}, "x effective address");
    end
    for (i = 0; i < 5; i++)
    begin
      a = $random(seed);
      b = $random(seed);
      k = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : a[25:16];
      both(1'b1, k, a[15:0], 1'b1, k, b[15:0]);
      both(1'b0, k, 16'h0, 1'b0, k, 16'h0);
      chk(x_rdata_r, a[15:0], "core wins");
      chk(dma_rdata_r, a[15:0], "dual read");
      both(1'b1, k, b[15:0], 1'b1, ~k, a[15:0]);
      both(1'b0, ~k, 16'h0, 1'b0, k, 16'h0);
      chk(x_rdata_r, a[15:0], "core sees dma");
      chk(dma_rdata_r, b[15:0], "dma sees core");
      x_acc = '0;
      i_dma.idle();
      mac_op = 1'b1;
      y_rd = 1'b1;
      y_addr = 16'hf800 + {5'h0, k, 1'b0};
      tick();
      chk(y_rdata_r, b[15:0], "y read");
      mac_op = 1'b0;
      y_addr = 16'hf800 + {5'h0, ~k, 1'b0};
      tick();
      y_rd = 1'b0;
      chk(y_rdata_r, b[15:0], "y without mac");
    end
    // Modulo wrap on both generators, then both read paths in one cycle.
    a = $random(seed);
    x_mod_lo = 16'h0100;
    x_mod_hi = 16'h01fe;
    y_mod_lo = 16'h0100;
    y_mod_hi = 16'h01fe;
    x_mode = DMEM_AM_MOD;
    x_acc = '{rd: 1'b0, wr: 1'b1, addr: 16'h0202, wdata: a[15:0]};
    tick();
    chk(x_ea_r, mod_ea(16'h0202, 16'h0100, 16'h01fe), "x modulo wrap");
    x_mode = DMEM_AM_LIN;
    x_acc = '{rd: 1'b1, wr: 1'b0, addr: mod_ea(16'h0202, 16'h0100, 16'h01fe), wdata: 16'h0};
    y_mod_en = 1'b1;
    y_addr = 16'h0202;
    mac_op = 1'b1;
    y_rd = 1'b1;
    tick();
    chk(x_rdata_r, a[15:0], "x after wrap");
    chk(y_rdata_r, a[15:0], "y modulo wrap");
    // Reversal on X writes only; clearing bits 4..0 keeps the mirror in populated RAM.
    b = $random(seed);
    x_mode = DMEM_AM_REV;
    x_mod_hi = 16'hfffe;
    y_mod_en = 1'b0;
    mac_op = 1'b0;
    y_rd = 1'b0;
    x_acc = '{rd: 1'b0, wr: 1'b1, addr: {b[15:5], 5'h00}, wdata: a[31:16]};
    tick();
    chk(x_ea_r, rev_ea({b[15:5], 5'h00}), "x reversed write");
    x_acc = '{rd: 1'b1, wr: 1'b0, addr: {b[15:5], 5'h00}, wdata: 16'h0};
    tick();
    chk(x_ea_r, {b[15:5], 5'h00}, "x read not reversed");
    x_mode = DMEM_AM_LIN;
    x_acc = '{rd: 1'b1, wr: 1'b0, addr: rev_ea({b[15:5], 5'h00}), wdata: 16'h0};
    tick();
    chk(x_rdata_r, a[31:16], "reversed write lands");
    // Just below the shared RAM nothing is populated; with DMA idle it serves as plain RAM.
    x_acc = '{rd: 1'b0, wr: 1'b1, addr: 16'hf7fe, wdata: b[31:16]};
    tick();
    x_acc = '{rd: 1'b1, wr: 1'b0, addr: 16'hf7fe, wdata: 16'h0};
    tick();
    chk(x_rdata_r, 24'h0, "below shared RAM");
    x_acc = '{rd: 1'b0, wr: 1'b1, addr: 16'hfffe, wdata: b[31:16]};
    tick();
    x_acc = '{rd: 1'b1, wr: 1'b0, addr: 16'hfffe, wdata: 16'h0};
    tick();
    chk(x_rdata_r, b[31:16], "shared RAM without DMA");
    summarize();
  end
endmodule // dsp_core_memory_organization_test
`default_nettype wire
